//--- rtl/rbd_top.sv
// Backup-domain real-time clock: prescaler, BCD calendar, alarms, wakeup timer,
// backup registers, backup SRAM and wake event routing, all behind an APB slave.
// Assumes slow clock pins are far slower than core_clk and power state inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin inputs
module rbd_sync #(
   parameter int unsigned W = 1
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_reg <= '0;
         q <= '0;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

module rbd_top #(
   parameter int unsigned BKP_NUM = 20,
   parameter int unsigned SRAM_WORDS = 1024
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rbd_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xtal_clk_pin,
   input wire logic rc_clk_pin,
   input wire logic fast_external_oscillator,
   input wire logic tamper_pin,
   input wire logic timestamp_pin,
   input wire logic wakeup_pin,
   input wire logic external_reset_pin_n,
   input wire logic independent_watchdog_reset,
   input wire logic standby_mode,
   input wire logic battery_mode,
   output logic irq,
   output logic cal_out,
   output logic [3:0] external_event_lines,
   output logic standby_exit
);
   import rbd_pkg::*;

   if (BKP_NUM < 1 || BKP_NUM > 32) begin : g_bkp_chk
      $error("BKP_NUM must lie in 1..32");
   end
   if (SRAM_WORDS < 2 || SRAM_WORDS > 1024 || $countones(SRAM_WORDS) != 1) begin : g_ram_chk
      $error("SRAM_WORDS must be a power of two up to 1024");
   end

   // Pins into the core domain
   logic [6:0] pin_s;
   logic [6:0] pin_d_reg;
   logic [6:0] rise;
   rbd_sync #(.W(7)) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .d({xtal_clk_pin, rc_clk_pin, fast_external_oscillator, tamper_pin, timestamp_pin,
          wakeup_pin, ~external_reset_pin_n}),
      .q(pin_s)
   );
   always_ff @(posedge core_clk) begin
      if (srst) pin_d_reg <= '0;
      else if (ce) pin_d_reg <= pin_s;
   end
   assign rise = pin_s & ~pin_d_reg;

   // Software registers
   logic [31:0] ctrl_reg;
   logic [6:0] async_rl_reg;
   logic [12:0] sync_rl_reg;
   logic [15:0] wake_rl_reg;
   logic [31:0] alm_reg [2];
   logic [31:0] ass_reg [2];
   logic [7:0] cal_skip_reg;
   logic [ST_W-1:0] stat_reg;
   logic [ST_W-1:0] mask_reg;
   logic [31:0] stamp_reg;
   logic [31:0] bkp_reg [BKP_NUM];
   logic [31:0] sram_mem [SRAM_WORDS];
   logic [1:0] src;
   assign src = ctrl_reg[CT_SRC +: 2];

   // Bus phases and decode
   logic setup;
   logic access;
   logic wr;
   logic bkp_hit;
   logic ram_hit;
   logic [4:0] bkp_idx;
   logic [$clog2(SRAM_WORDS)-1:0] ram_idx;
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign bkp_idx = paddr[6:2];
   assign ram_idx = paddr[$clog2(SRAM_WORDS)+1:2];
   assign bkp_hit = (paddr[12:7] == BKP_PAGE) && (32'(bkp_idx) < BKP_NUM);
   assign ram_hit = paddr[12] && (32'(paddr[11:2]) < SRAM_WORDS);

   // Slow tick from the chosen source; the fast oscillator is divided first
   logic [6:0] fast_cnt_reg;
   logic raw_tick;
   always_ff @(posedge core_clk) begin
      if (srst) fast_cnt_reg <= '0;
      else if (ce && rise[4]) fast_cnt_reg <= fast_cnt_reg + 7'h01;
   end
   always_comb begin
      case (src)
         RBD_SRC_XTAL: raw_tick = rise[6];
         RBD_SRC_RC: raw_tick = rise[5];
         RBD_SRC_FAST: raw_tick = rise[4] && (32'(fast_cnt_reg) == FAST_DIV - 1);
         default: raw_tick = 1'b0;
      endcase
   end

   // Trim: drop the first cal_skip ticks of every window, slowing a fast crystal
   logic [CAL_WIN_W-1:0] cal_win_reg;
   logic ls_tick;
   assign ls_tick = raw_tick && (cal_win_reg >= CAL_WIN_W'(cal_skip_reg));
   always_ff @(posedge core_clk) begin
      if (srst) cal_win_reg <= '0;
      else if (ce && raw_tick) cal_win_reg <= cal_win_reg + 1'b1;
   end

   // 20-bit prescaler: 7 asynchronous plus 13 synchronous bits, both counting down
   logic [6:0] async_cnt_reg;
   logic [12:0] sync_cnt_reg;
   logic apre_tick;
   logic spre_tick;
   logic cal_load;
   assign apre_tick = ls_tick && (async_cnt_reg == 7'h00);
   assign spre_tick = apre_tick && (sync_cnt_reg == 13'h0000);
   always_ff @(posedge core_clk) begin
      if (srst) begin
         async_cnt_reg <= ASYNC_RST;
         sync_cnt_reg <= SYNC_RST;
      end else if (ce) begin
         if (cal_load) begin
            async_cnt_reg <= async_rl_reg;
            sync_cnt_reg <= sync_rl_reg;
         end else if (ls_tick) begin
            async_cnt_reg <= apre_tick ? async_rl_reg : async_cnt_reg - 7'h01;
            if (apre_tick) sync_cnt_reg <= spre_tick ? sync_rl_reg : sync_cnt_reg - 13'h0001;
         end
      end
   end

   // 512 Hz square wave from a 32.768 kHz base
   logic [4:0] calo_cnt_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         calo_cnt_reg <= '0;
         cal_out <= 1'b0;
      end else if (ce) begin
         if (!ctrl_reg[CT_CALO]) begin
            calo_cnt_reg <= '0;
            cal_out <= 1'b0;
         end else if (ls_tick) begin
            calo_cnt_reg <= calo_cnt_reg + 5'h01;
            if (32'(calo_cnt_reg) == CALO_HALF - 1) cal_out <= ~cal_out;
         end
      end
   end

   // BCD calendar
   logic [6:0] sec_reg;
   logic [6:0] min_reg;
   logic [5:0] hour_reg;
   logic pm_reg;
   logic [5:0] date_reg;
   logic [4:0] month_reg;
   logic [2:0] wday_reg;
   logic [7:0] year_reg;
   logic [31:0] time_word;
   logic [31:0] date_word;
   logic [7:0] sec_inc, min_inc, hour_inc, date_inc, month_inc, year_inc;
   logic [5:0] last_day;
   logic leap;
   logic fmt12;
   assign fmt12 = ctrl_reg[CT_FMT12];
   assign time_word = {9'h000, pm_reg, hour_reg, 1'b0, min_reg, 1'b0, sec_reg};
   assign date_word = {8'h00, year_reg, wday_reg, month_reg, 2'b00, date_reg};
   assign cal_load = wr && (paddr == OFF_TIME || paddr == OFF_DATE);

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // Leap years: BCD year divisible by four
   assign leap = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6)
                             : (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 ||
                                year_reg[3:0] == 4'h8);
   always_comb begin
      sec_inc = bcd_inc({1'b0, sec_reg});
      min_inc = bcd_inc({1'b0, min_reg});
      hour_inc = bcd_inc({2'b00, hour_reg});
      date_inc = bcd_inc({2'b00, date_reg});
      month_inc = bcd_inc({3'b000, month_reg});
      year_inc = bcd_inc(year_reg);
      case (month_reg)
         5'h02: last_day = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
         default: last_day = 6'h31;
      endcase
   end

   // Calendar step on each second; a software write wins over the step
   always_ff @(posedge core_clk) begin
      if (srst) begin
         {pm_reg, hour_reg, min_reg, sec_reg} <= '0;
         {year_reg, wday_reg, month_reg, date_reg} <= {DATE_RST[23:13], DATE_RST[12:8],
                                                       DATE_RST[5:0]};
      end else if (ce) begin
         if (wr && paddr == OFF_TIME) begin
            {pm_reg, hour_reg} <= pwdata[22:16];
            min_reg <= pwdata[14:8];
            sec_reg <= pwdata[6:0];
         end else if (wr && paddr == OFF_DATE) begin
            {year_reg, wday_reg, month_reg} <= pwdata[23:8];
            date_reg <= pwdata[5:0];
         end else if (spre_tick) begin
            sec_reg <= (sec_reg == 7'h59) ? 7'h00 : sec_inc[6:0];
            if (sec_reg == 7'h59) begin
               min_reg <= (min_reg == 7'h59) ? 7'h00 : min_inc[6:0];
               if (min_reg == 7'h59) begin
                  if (fmt12 ? (hour_reg == 6'h11 && pm_reg) : (hour_reg == 6'h23)) begin
                     wday_reg <= (wday_reg == 3'h7) ? 3'h1 : wday_reg + 3'h1;
                     if (date_reg == last_day) begin
                        date_reg <= 6'h01;
                        month_reg <= (month_reg == 5'h12) ? 5'h01 : month_inc[4:0];
                        if (month_reg == 5'h12) year_reg <= (year_reg == 8'h99) ? 8'h00 : year_inc;
                     end else begin
                        date_reg <= date_inc[5:0];
                     end
                  end
                  if (!fmt12) hour_reg <= (hour_reg == 6'h23) ? 6'h00 : hour_inc[5:0];
                  else if (hour_reg == 6'h12) hour_reg <= 6'h01;
                  else hour_reg <= hour_inc[5:0];
                  if (fmt12 && hour_reg == 6'h11) pm_reg <= ~pm_reg;
               end
            end
         end
      end
   end

   // Alarm compare one cycle after the prescaler step, when the calendar has settled
   logic eval_reg;
   logic sec_evt_reg;
   logic [1:0] alm_evt;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         eval_reg <= 1'b0;
         sec_evt_reg <= 1'b0;
      end else if (ce) begin
         eval_reg <= apre_tick && !cal_load;
         sec_evt_reg <= spre_tick && !cal_load;
      end
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         alm_evt[i] = eval_reg && ctrl_reg[CT_ALM_A + i] &&
            (alm_reg[i][7] || alm_reg[i][6:0] == sec_reg) &&
            (alm_reg[i][15] || alm_reg[i][14:8] == min_reg) &&
            (alm_reg[i][23] || (alm_reg[i][21:16] == hour_reg &&
                                (!fmt12 || alm_reg[i][22] == pm_reg))) &&
            (alm_reg[i][31] || (alm_reg[i][30] ? alm_reg[i][26:24] == wday_reg
                                               : alm_reg[i][29:24] == date_reg)) &&
            (ass_reg[i][31] ? sec_evt_reg : ass_reg[i][12:0] == sync_cnt_reg);
      end
   end

   // Wakeup timer: resolution is slow clock / 16, 8, 4, 2 or one second
   logic [3:0] wdiv_reg;
   logic [15:0] wcnt_reg;
   logic [2:0] wsel;
   logic wtick;
   logic wake_evt;
   assign wsel = ctrl_reg[CT_WSEL +: 3];
   always_comb begin
      case (wsel)
         3'h0: wtick = ls_tick && wdiv_reg == 4'hF;
         3'h1: wtick = ls_tick && wdiv_reg[2:0] == 3'h7;
         3'h2: wtick = ls_tick && wdiv_reg[1:0] == 2'h3;
         3'h3: wtick = ls_tick && wdiv_reg[0];
         default: wtick = spre_tick;
      endcase
   end
   assign wake_evt = ctrl_reg[CT_WAKE_EN] && wtick && wcnt_reg == 16'h0000;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wdiv_reg <= '0;
         wcnt_reg <= WAKE_RST;
      end else if (ce) begin
         if (ls_tick) wdiv_reg <= wdiv_reg + 4'h1;
         if (!ctrl_reg[CT_WAKE_EN]) wcnt_reg <= wake_rl_reg;
         else if (wtick) wcnt_reg <= wake_evt ? wake_rl_reg : wcnt_reg - 16'h0001;
      end
   end

   // Sticky status: a new event beats a same-cycle write-one clear
   logic [ST_W-1:0] ev_set;
   logic [ST_W-1:0] ev_clr;
   assign ev_set = {rise[2], rise[3], wake_evt, alm_evt};
   assign ev_clr = (wr && paddr == OFF_STAT) ? pwdata[ST_W-1:0] : '0;
   always_ff @(posedge core_clk) begin
      if (srst) stat_reg <= '0;
      else if (ce) stat_reg <= (stat_reg & ~ev_clr) | ev_set;
   end
   assign irq = |(stat_reg & mask_reg);

   // Timestamp capture on the pin edge
   always_ff @(posedge core_clk) begin
      if (srst) stamp_reg <= '0;
      else if (ce && rise[2]) stamp_reg <= time_word;
   end

   // Wake routing; battery operation blocks every exit and every event line
   always_ff @(posedge core_clk) begin
      if (srst) begin
         external_event_lines <= '0;
         standby_exit <= 1'b0;
      end else if (ce) begin
         external_event_lines <= battery_mode ? 4'h0 :
            {ev_set[ST_STAMP], ev_set[ST_TAMP], wake_evt, |alm_evt};
         standby_exit <= standby_mode && !battery_mode &&
            (pin_s[0] || independent_watchdog_reset || rise[1] || |ev_set);
      end
   end

   // Register writes; backup registers take no reset at all
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_reg <= '0;
         async_rl_reg <= ASYNC_RST;
         sync_rl_reg <= SYNC_RST;
         wake_rl_reg <= WAKE_RST;
         alm_reg <= '{default: '0};
         ass_reg <= '{default: ASS_RST};
         cal_skip_reg <= '0;
         mask_reg <= '0;
      end else if (ce && wr) begin
         case (paddr)
            OFF_CTRL: ctrl_reg <= {21'h000000, pwdata[10:0]};
            OFF_PRESC: {async_rl_reg, sync_rl_reg} <= {pwdata[22:16], pwdata[12:0]};
            OFF_WAKE: wake_rl_reg <= pwdata[15:0];
            OFF_ALM_A: alm_reg[0] <= pwdata;
            OFF_ALM_B: alm_reg[1] <= pwdata;
            OFF_ASS_A: ass_reg[0] <= {pwdata[31], 18'h00000, pwdata[12:0]};
            OFF_ASS_B: ass_reg[1] <= {pwdata[31], 18'h00000, pwdata[12:0]};
            OFF_CAL: cal_skip_reg <= pwdata[7:0];
            OFF_MASK: mask_reg <= pwdata[ST_W-1:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (ce && wr && bkp_hit) bkp_reg[bkp_idx] <= pwdata;
   end
   always_ff @(posedge core_clk) begin
      if (ce && wr && ram_hit && ctrl_reg[CT_SRAM_EN]) sram_mem[ram_idx] <= pwdata;
   end

   // Read mux; read-only words ignore writes without error
   logic [31:0] rd_mux;
   logic rd_err;
   always_comb begin
      rd_err = 1'b0;
      case (paddr)
         OFF_TIME: rd_mux = time_word;
         OFF_DATE: rd_mux = date_word;
         OFF_CTRL: rd_mux = ctrl_reg;
         OFF_PRESC: rd_mux = {9'h000, async_rl_reg, 3'h0, sync_rl_reg};
         OFF_SUBSEC: rd_mux = {19'h00000, sync_cnt_reg};
         OFF_WAKE: rd_mux = {16'h0000, wake_rl_reg};
         OFF_ALM_A: rd_mux = alm_reg[0];
         OFF_ALM_B: rd_mux = alm_reg[1];
         OFF_ASS_A: rd_mux = ass_reg[0];
         OFF_ASS_B: rd_mux = ass_reg[1];
         OFF_CAL: rd_mux = {24'h000000, cal_skip_reg};
         OFF_STAT: rd_mux = {27'h0000000, stat_reg};
         OFF_MASK: rd_mux = {27'h0000000, mask_reg};
         OFF_STAMP: rd_mux = stamp_reg;
         default: begin
            rd_mux = bkp_hit ? bkp_reg[bkp_idx] : 32'h0000_0000;
            rd_err = !bkp_hit && !(ram_hit && ctrl_reg[CT_SRAM_EN]);
         end
      endcase
   end

   // Data and error captured in the setup cycle; access completes with no wait
   logic err_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prdata <= '0;
         err_reg <= 1'b0;
      end else if (ce && setup) begin
         err_reg <= rd_err;
         if (ram_hit) prdata <= ctrl_reg[CT_SRAM_EN] ? sram_mem[ram_idx] : 32'h0000_0000;
         else prdata <= rd_mux;
      end
   end
   assign pready = 1'b1;
   assign pslverr = access && err_reg;
endmodule

`default_nettype wire

//--- common/rbd_pkg.sv
// Constants for the backup-domain real-time clock: register map, fields, resets, timing.
// Assumes a 32-bit APB master and a 25 MHz core clock; slow clocks arrive as plain pins.
package rbd_pkg;
   localparam int unsigned ADDR_W = 13;
   // Byte offsets
   localparam logic [12:0] OFF_TIME = 13'h0000;
   localparam logic [12:0] OFF_DATE = 13'h0004;
   localparam logic [12:0] OFF_CTRL = 13'h0008;
   localparam logic [12:0] OFF_PRESC = 13'h000C;
   localparam logic [12:0] OFF_SUBSEC = 13'h0010;
   localparam logic [12:0] OFF_WAKE = 13'h0014;
   localparam logic [12:0] OFF_ALM_A = 13'h0018;
   localparam logic [12:0] OFF_ALM_B = 13'h001C;
   localparam logic [12:0] OFF_ASS_A = 13'h0020;
   localparam logic [12:0] OFF_ASS_B = 13'h0024;
   localparam logic [12:0] OFF_CAL = 13'h0028;
   localparam logic [12:0] OFF_STAT = 13'h002C;
   localparam logic [12:0] OFF_MASK = 13'h0030;
   localparam logic [12:0] OFF_STAMP = 13'h0034;
   localparam logic [5:0] BKP_PAGE = 6'h01; // Backup registers from 0x080
   // Control fields
   localparam int unsigned CT_SRC = 0; // Two bits
   localparam int unsigned CT_CALO = 2;
   localparam int unsigned CT_WAKE_EN = 3;
   localparam int unsigned CT_ALM_A = 4;
   localparam int unsigned CT_ALM_B = 5;
   localparam int unsigned CT_FMT12 = 6;
   localparam int unsigned CT_SRAM_EN = 7;
   localparam int unsigned CT_WSEL = 8; // Three bits
   // Status bits
   localparam int unsigned ST_ALM = 0; // Two bits, A then B
   localparam int unsigned ST_WAKE = 2;
   localparam int unsigned ST_TAMP = 3;
   localparam int unsigned ST_STAMP = 4;
   localparam int unsigned ST_W = 5;
   // Reset values
   localparam logic [6:0] ASYNC_RST = 7'h7F;
   localparam logic [12:0] SYNC_RST = 13'h00FF;
   localparam logic [15:0] WAKE_RST = 16'hFFFF;
   localparam logic [31:0] DATE_RST = 32'h0000_2101;
   localparam logic [31:0] ASS_RST = 32'h8000_0000;
   // Timing: fast-oscillator edges per tick, half-period in slow-clock ticks, trim window width in bits
   localparam int unsigned FAST_DIV = 128;
   localparam int unsigned CALO_HALF = 32; // 32768 / 512 / 2
   localparam int unsigned CAL_WIN_W = 20;
   typedef enum logic [1:0] {
      RBD_SRC_XTAL = 2'b00,
      RBD_SRC_RC = 2'b01,
      RBD_SRC_FAST = 2'b10,
      RBD_SRC_OFF = 2'b11
   } rbd_src_e;
endpackage

//--- tb/rbd_top_asserts.sv
// Port-level assertion checker for the backup-domain real-time clock top.
// Assumes it is bound to rbd_top and that everything runs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module rbd_top_asserts (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic independent_watchdog_reset,
   input wire logic standby_mode,
   input wire logic battery_mode,
   input wire logic irq,
   input wire logic cal_out,
   input wire logic [3:0] external_event_lines,
   input wire logic standby_exit
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // Battery operation seen on two edges, so the registered outputs have caught up
   sequence s_batt;
      battery_mode ##1 battery_mode;
   endsequence
   // Watchdog reset while asleep on main supply
   sequence s_wdog_wake;
      ce && standby_mode && !battery_mode && independent_watchdog_reset;
   endsequence
   chk_irq_after_rst: assert property ($fell(srst) |-> !irq)
      else $error("irq high right after reset");
   chk_cal_after_rst: assert property ($fell(srst) |-> !cal_out)
      else $error("calibration output high right after reset");
   chk_batt_events: assert property (s_batt |-> external_event_lines == 4'h0)
      else $error("event line pulsed in battery operation");
   chk_batt_no_exit: assert property (s_batt |-> !standby_exit)
      else $error("standby exit in battery operation");
   chk_exit_cause: assert property (standby_exit |->
      $past(standby_mode && !battery_mode))
      else $error("standby exit without standby on main supply");
   chk_wdog_exit: assert property (s_wdog_wake |=> standby_exit)
      else $error("watchdog reset did not end standby");
   chk_err_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   chk_err_rdata: assert property (psel && penable && !pwrite && pslverr |->
      prdata == 32'h0000_0000)
      else $error("refused read returned data");
   chk_wake_pulse: assert property (external_event_lines[1] |=> !external_event_lines[1])
      else $error("wakeup event line longer than one cycle");
endmodule
`default_nettype wire

//--- tb/tb_rbd_top.sv
// Self-checking bench for the backup-domain real-time clock over APB.
// Assumes slow pins are toggled far slower than core_clk, as the block samples them.
`timescale 1ns/1ps
`default_nettype none
module tb_rbd_top;
   import rbd_pkg::*;
   typedef struct {logic [31:0] c; int p; int n; logic [31:0] t0, d0, t1, d1;} rbd_row_s;
   logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq, cal_out, standby_exit;
   logic wdog, stby, batt, rerr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] pins;
   logic [3:0] ev;
   int err_count = 0;
   int n_compared = 0;
   // Reset register values; the last two places are refused
   logic [12:0] r_addr [9] = '{OFF_TIME, OFF_DATE, OFF_CTRL, OFF_PRESC, OFF_WAKE, OFF_ASS_A,
      OFF_STAT, 13'h0038, 13'h1000};
   logic [31:0] r_data [9] = '{32'h0000_0000, DATE_RST, 32'h0000_0000,
      {9'h000, ASYNC_RST, 3'h0, SYNC_RST}, {16'h0000, WAKE_RST}, ASS_RST, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000};
   // Calendar and clock-source cases: control, pin, edges, time/date before and after
   rbd_row_s rows [9] = '{
      '{32'h0000_0000, 0, 1, 32'h0023_5959, 32'h0023_4228, 32'h0000_0000, 32'h0023_6301},
      '{32'h0000_0000, 0, 1, 32'h0023_5959, 32'h0024_4228, 32'h0000_0000, 32'h0024_6229},
      '{32'h0000_0000, 0, 1, 32'h0023_5959, 32'h0024_E430, 32'h0000_0000, 32'h0024_2501},
      '{32'h0000_0000, 0, 1, 32'h0023_5959, 32'h0025_2131, 32'h0000_0000, 32'h0025_4201},
      '{32'h0000_0000, 0, 1, 32'h0023_5959, 32'h0099_B231, 32'h0000_0000, 32'h0000_C101},
      '{32'h0000_0040, 0, 1, 32'h0011_5959, 32'h0000_2101, 32'h0052_0000, 32'h0000_2101},
      '{32'h0000_0001, 1, 1, 32'h0000_0000, 32'h0000_2101, 32'h0000_0001, 32'h0000_2101},
      '{32'h0000_0002, 2, 128, 32'h0000_0000, 32'h0000_2101, 32'h0000_0001, 32'h0000_2101},
      '{32'h0000_0003, 0, 1, 32'h0000_0000, 32'h0000_2101, 32'h0000_0000, 32'h0000_2101}};

   rbd_top i_rbd_top (.core_clk(core_clk), .srst(srst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .xtal_clk_pin(pins[0]), .rc_clk_pin(pins[1]),
      .fast_external_oscillator(pins[2]), .tamper_pin(pins[3]), .timestamp_pin(pins[4]),
      .wakeup_pin(pins[5]), .external_reset_pin_n(1'b1), .independent_watchdog_reset(wdog),
      .standby_mode(stby), .battery_mode(batt), .irq(irq), .cal_out(cal_out),
      .external_event_lines(ev), .standby_exit(standby_exit));

   // 25 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge, holds until pready is seen
   task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never re-raises psel in the same time step
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [12:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0000_0000);
      cmp32(rd, exp);
      cmp32({31'h0, rerr}, {31'h0, experr});
   endtask

   // Slow pins toggle every six core cycles, leaving room for the input synchronisers
   task automatic tick(input int p, input int n);
      repeat (n) begin
         pins[p] <= 1'b1;
         repeat (6) @(posedge core_clk);
         pins[p] <= 1'b0;
         repeat (6) @(posedge core_clk);
      end
   endtask

   // Watch for a standby exit within ten cycles
   task automatic wait_exit(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(posedge core_clk);
         seen = seen | (standby_exit === 1'b1);
      end
      cmp32({31'h0, seen}, {31'h0, exp});
   endtask

   // Hang guard, far above the few thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pins = '0;
      wdog = 1'b0;
      stby = 1'b0;
      batt = 1'b0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      foreach (r_addr[i]) rdchk(r_addr[i], r_data[i], i > 6);
      // Backup registers must outlive a reset; index twenty is refused
      wr(13'h0080, 32'hA5A5_0001);
      wr(13'h00CC, 32'h5A5A_0013);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rdchk(13'h0080, 32'hA5A5_0001, 1'b0);
      rdchk(13'h00CC, 32'h5A5A_0013, 1'b0);
      rdchk(13'h00D0, 32'h0000_0000, 1'b1);
      wr(OFF_CTRL, 32'h0000_0080);
      wr(13'h1FFC, 32'h1234_5678);
      rdchk(13'h1FFC, 32'h1234_5678, 1'b0);
      // Sub-second count runs down in binary and ignores writes
      wr(OFF_PRESC, 32'h0000_0003);
      wr(OFF_TIME, 32'h0000_0000);
      tick(0, 1);
      wr(OFF_SUBSEC, 32'h0000_0055);
      rdchk(OFF_SUBSEC, 32'h0000_0002, 1'b0);
      wr(OFF_PRESC, 32'h0000_0000);
      foreach (rows[i]) begin
         wr(OFF_CTRL, rows[i].c);
         wr(OFF_TIME, rows[i].t0);
         wr(OFF_DATE, rows[i].d0);
         tick(rows[i].p, rows[i].n);
         rdchk(OFF_TIME, rows[i].t1, 1'b0);
         rdchk(OFF_DATE, rows[i].d1, 1'b0);
      end
      // Both alarms on seconds only, then mask and clear the interrupt
      wr(OFF_ALM_A, 32'h8080_8005);
      wr(OFF_ALM_B, 32'h8080_8005);
      wr(OFF_CTRL, 32'h0000_0030);
      wr(OFF_MASK, 32'h0000_0001);
      wr(OFF_TIME, 32'h0000_0004);
      tick(0, 1);
      rdchk(OFF_STAT, 32'h0000_0003, 1'b0);
      cmp32({31'h0, irq}, 32'h0000_0001);
      wr(OFF_MASK, 32'h0000_0000);
      @(posedge core_clk);
      cmp32({31'h0, irq}, 32'h0000_0000);
      wr(OFF_STAT, 32'h0000_0003);
      tick(0, 1);
      rdchk(OFF_STAT, 32'h0000_0000, 1'b0);
      // Wakeup timer at one tick per second, reload one gives a period of two
      wr(OFF_WAKE, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_0408);
      tick(0, 1);
      rdchk(OFF_STAT, 32'h0000_0000, 1'b0);
      tick(0, 1);
      rdchk(OFF_STAT, 32'h0000_0004, 1'b0);
      // Calibration output toggles after half a 512 Hz period of crystal ticks
      wr(OFF_CTRL, 32'h0000_0004);
      tick(0, CALO_HALF - 1);
      cmp32({31'h0, cal_out}, 32'h0000_0000);
      tick(0, 1);
      cmp32({31'h0, cal_out}, 32'h0000_0001);
      // Time changes between tamper and timestamp edges, so the stamp shows which one captured
      wr(OFF_STAT, 32'h0000_001F);
      tick(3, 1);
      wr(OFF_TIME, 32'h0012_3456);
      tick(4, 1);
      rdchk(OFF_STAT, 32'h0000_0018, 1'b0);
      rdchk(OFF_STAMP, 32'h0012_3456, 1'b0);
      // Standby exits: wakeup pin, blocked on battery, then watchdog
      stby <= 1'b1;
      pins[5] <= 1'b1;
      wait_exit(1'b1);
      pins[5] <= 1'b0;
      batt <= 1'b1;
      repeat (4) @(posedge core_clk);
      pins[5] <= 1'b1;
      wait_exit(1'b0);
      batt <= 1'b0;
      wdog <= 1'b1;
      wait_exit(1'b1);
      print_verdict();
   end
endmodule

bind rbd_top rbd_top_asserts i_rbd_top_asserts (.core_clk(core_clk), .srst(srst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
   .independent_watchdog_reset(independent_watchdog_reset), .standby_mode(standby_mode),
   .battery_mode(battery_mode), .irq(irq), .cal_out(cal_out),
   .external_event_lines(external_event_lines), .standby_exit(standby_exit));
`default_nettype wire
